// File: core/lrs_port.v
// Purpose: i2c slave giving a bus master access to 8-bit registers
// Assumes: register file outside; rd_data_i valid for reg_ptr_o same cycle
// Notes: writes are staged and applied as a burst of commit pulses at stop
`include "lrs_regs.vh"
`default_nettype none
module lrs_port
#(
  parameter VARIANT_B = 0,
  parameter DEPTH     = 32,
  parameter AW        = 5
)
(
  input  wire       ref_clk_i,
  input  wire       rstn_i,
  input  wire       ce_i,
  input  wire       en_i,
  input  wire       uvlo_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  output reg        scl_o,
  output reg        scl_oe_o,
  output reg  [7:0] reg_ptr_o,
  input  wire [7:0] rd_data_i,
  output reg        wr_stb_o,
  output reg  [7:0] wr_addr_o,
  output reg  [7:0] wr_data_o,
  output reg        busy_o
);
  wire       scl_f;
  wire       sda_f;
  reg        scl_d;
  reg        sda_d;
  reg        en_m;
  reg        en_s;
  reg        uv_m;
  reg        uv_s;
  reg  [2:0] state;
  reg  [3:0] bitc;
  reg  [7:0] shreg;
  reg  [7:0] ptr;
  reg        ptr_loaded;
  reg        is_read;
  reg        ack_drv;
  reg  [7:0] pend_data [0:DEPTH-1];
  reg  [7:0] pend_addr [0:DEPTH-1];
  reg [AW:0] pend_cnt;
  reg [AW:0] cmt_idx;
  reg        committing;
  integer    i;

  // =====================================================================
  // line conditioning
  lrs_filter u_scl
  (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .din_i     (scl_i),
    .dout_o    (scl_f)
  );
  lrs_filter u_sda
  (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .din_i     (sda_i),
    .dout_o    (sda_f)
  );

  wire active   = en_s & ~uv_s;                        // see RL2 see RL16
  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_c  = scl_f & scl_d & sda_d & ~sda_f;     // see RL9 see RL11
  wire stop_c   = scl_f & scl_d & ~sda_d & sda_f;     // see RL9
  wire [6:0] my_addr = (VARIANT_B != 0) ? `LRS_ADDR_B : `LRS_ADDR_A; // see RL3
  wire [7:0] rx_byte = {shreg[6:0], sda_f};
  wire pend_full = (pend_cnt == DEPTH[AW:0]);

  // =====================================================================
  // bus engine
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      en_m       <= 1'b0;
      en_s       <= 1'b0;
      uv_m       <= 1'b1;
      uv_s       <= 1'b1;
      state      <= `LRS_ST_IDLE;
      bitc       <= `LRS_BIT_ZERO;
      shreg      <= 8'h00;
      ptr        <= 8'h00;
      ptr_loaded <= 1'b0;
      is_read    <= 1'b0;
      ack_drv    <= 1'b0;
      pend_cnt   <= {(AW+1){1'b0}};
      cmt_idx    <= {(AW+1){1'b0}};
      committing <= 1'b0;
      sda_o      <= 1'b0;
      sda_oe_o   <= 1'b0;
      scl_o      <= 1'b0;
      scl_oe_o   <= 1'b0;
      reg_ptr_o  <= 8'h00;
      wr_stb_o   <= 1'b0;
      wr_addr_o  <= 8'h00;
      wr_data_o  <= 8'h00;
      busy_o     <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1)
      begin
        pend_data[i] <= 8'h00;
        pend_addr[i] <= 8'h00;
      end
    end
    else if (ce_i)
    begin
      scl_d     <= scl_f;
      sda_d     <= sda_f;
      en_m      <= en_i;
      en_s      <= en_m;
      uv_m      <= uvlo_i;
      uv_s      <= uv_m;
      scl_o     <= 1'b0;
      scl_oe_o  <= 1'b0; // slave never stretches the clock, see RL1 see RL13
      wr_stb_o  <= 1'b0;
      reg_ptr_o <= ptr;
      sda_o     <= 1'b0;
      sda_oe_o  <= ack_drv & active; // open drain: only ever pulls low, see RL14
      // staged writes drain one per cycle once stop has been seen
      if (committing)
      begin
        if (cmt_idx == pend_cnt)
        begin
          committing <= 1'b0;
          pend_cnt   <= {(AW+1){1'b0}};
        end
        else
        begin
          wr_stb_o  <= 1'b1; // see RL6
          wr_addr_o <= pend_addr[cmt_idx[AW-1:0]];
          wr_data_o <= pend_data[cmt_idx[AW-1:0]];
          cmt_idx   <= cmt_idx + {{AW{1'b0}}, 1'b1};
        end
      end
      if (!active)
      begin
        state   <= `LRS_ST_IDLE; // see RL2 see RL16
        ack_drv <= 1'b0;
        busy_o  <= 1'b0;
      end
      else if (start_c)
      begin
        state      <= `LRS_ST_ADDR; // see RL11
        // the scl fall that closes a start carries no bit: it wraps the count to zero
        bitc       <= `LRS_BIT_PRE; // see RL12
        ack_drv    <= 1'b0;
        ptr_loaded <= 1'b0;
        busy_o     <= 1'b1; // see RL10
      end
      else if (stop_c)
      begin
        state   <= `LRS_ST_IDLE;
        ack_drv <= 1'b0;
        busy_o  <= 1'b0;
        if (!committing && pend_cnt != {(AW+1){1'b0}})
        begin
          committing <= 1'b1; // see RL6 see RL7
          cmt_idx    <= {(AW+1){1'b0}};
        end
      end
      else if (state != `LRS_ST_IDLE)
      begin
        if (scl_rise)
        begin
          // data sampled only while scl high, see RL8 see RL12
          if (bitc <= `LRS_BIT_LAST)
            shreg <= rx_byte;
          if (bitc == `LRS_BIT_ACK && state == `LRS_ST_MACK)
          begin
            if (sda_f)
              state <= `LRS_ST_IDLE; // nack ends the read, see RL15 see RL20
            else
              state <= `LRS_ST_TXD;
          end
        end
        else if (scl_fall)
        begin
          // sda is changed only just after scl falls, see RL8
          if (bitc == `LRS_BIT_LAST)
          begin
            bitc    <= `LRS_BIT_ACK;
            ack_drv <= 1'b0;
            case (state)
              `LRS_ST_ADDR:
              begin
                if (shreg[7:1] == my_addr)
                begin
                  ack_drv <= 1'b1; // see RL5
                  is_read <= shreg[0]; // see RL4
                end
                else
                  state <= `LRS_ST_IDLE; // see RL5
              end
              `LRS_ST_RXD:
              begin
                if (!ptr_loaded)
                begin
                  ptr        <= shreg; // see RL17 see RL18
                  ptr_loaded <= 1'b1;
                  ack_drv    <= 1'b1;
                end
                else if (!pend_full && !committing)
                begin
                  pend_addr[pend_cnt[AW-1:0]] <= ptr; // see RL21
                  pend_data[pend_cnt[AW-1:0]] <= shreg;
                  pend_cnt <= pend_cnt + {{AW{1'b0}}, 1'b1};
                  ptr      <= ptr + 8'h01; // see RL17
                  ack_drv  <= 1'b1;
                end
              end
              `LRS_ST_TXD:
              begin
                ptr   <= ptr + 8'h01; // see RL17 see RL20
                state <= `LRS_ST_MACK; // see RL14
              end
              default:
                state <= `LRS_ST_IDLE;
            endcase
          end
          else if (bitc == `LRS_BIT_ACK)
          begin
            bitc    <= `LRS_BIT_ZERO;
            ack_drv <= 1'b0;
            if (state == `LRS_ST_ADDR)
              state <= is_read ? `LRS_ST_TXD : `LRS_ST_RXD; // see RL19
            if (state == `LRS_ST_RXD && !ack_drv)
              state <= `LRS_ST_IDLE; // refused byte: stay off bus
            if ((state == `LRS_ST_TXD) || (state == `LRS_ST_ADDR && is_read))
              ack_drv <= ~rd_data_i[7]; // msb first, see RL12
          end
          else
          begin
            bitc <= bitc + 4'h1;
            if (state == `LRS_ST_TXD)
              ack_drv <= ~rd_data_i[3'h6 - bitc[2:0]]; // see RL12
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: core/lrs_regs.vh
// Purpose: constants for the serial register port of the led driver
// Assumes: 50 MHz ref_clk_i, scl up to 400 kHz, sampled by ref_clk_i
// Notes: included by lrs_port.v and lrs_filter.v
// How it works
// RL1: slave only, fast mode up to 400 kHz
// RL2: enable low ignores bus, releases lines
// RL3: fixed address 28h or 29h by variant
// RL4: eighth address bit selects read or write
// RL5: ack address match, else idle till start
// RL6: written values held, applied at stop
// RL7: master stops early for partial updates
// RL8: sda changes only while scl low
// RL9: start and stop detected while scl high
// RL10: master makes start and stop always
// RL11: start before stop is repeated start
// RL12: eight bits msb first plus ack
// RL13: master supplies every scl pulse
// RL14: transmitter releases sda, receiver acks low
// RL15: after nack master stops or restarts
// RL16: undervoltage lockout also silences the port
// RL17: first write byte loads pointer, auto-increment
// RL18: single write is addr, reg, data, stop
// RL19: read uses repeated start with read bit
// RL20: read continues only on master ack
// RL21: eight-bit registers, one byte each
// RL22: lines synchronised and filtered before detection
`ifndef LRS_REGS_VH
`define LRS_REGS_VH
// =====================================================================
// addresses
`define LRS_ADDR_A     7'h28
`define LRS_ADDR_B     7'h29
// =====================================================================
// framing and filter length
`define LRS_BIT_LAST   4'h7
`define LRS_BIT_ACK    4'h8
`define LRS_BIT_ZERO   4'h0
`define LRS_BIT_PRE    4'hf
`define LRS_FILT_LEN   2'h3
// =====================================================================
// states
`define LRS_ST_IDLE    3'h0
`define LRS_ST_ADDR    3'h1
`define LRS_ST_RXD     3'h2
`define LRS_ST_TXD     3'h3
`define LRS_ST_MACK    3'h4
`endif

// File: core/lrs_filter.v
// Purpose: two-flop synchroniser plus consecutive-run glitch filter
// Assumes: input asynchronous to ref_clk_i
// Notes: output changes only after a stable run of samples
`include "lrs_regs.vh"
`default_nettype none
module lrs_filter
(
  input  wire ref_clk_i,
  input  wire rstn_i,
  input  wire ce_i,
  input  wire din_i,
  output reg  dout_o
);
  reg       meta;
  reg       sync;
  reg [1:0] cnt;
  // =====================================================================
  // synchroniser and filter
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta   <= 1'b1;
      sync   <= 1'b1;
      cnt    <= 2'h0;
      dout_o <= 1'b1;
    end
    else if (ce_i)
    begin
      meta <= din_i;
      sync <= meta; // see RL22
      // short spikes never reach the edge detectors
      if (sync == dout_o)
        cnt <= 2'h0;
      else if (cnt == `LRS_FILT_LEN)
      begin
        cnt    <= 2'h0;
        dout_o <= sync; // see RL22
      end
      else
        cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/lrs_monitor.sv
// Purpose: port-level assertions for lrs_port
// Assumes: scl low and high halves far longer than the 6-cycle filter lag
// Notes: raw line levels lead the filtered ones, so bounds allow 16 cycles
`default_nettype none
module lrs_monitor
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic uvlo_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic wr_stb_o,
  input wire logic busy_o
);
  // ====================
  // bus rules
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_scl; !scl_oe_o && !scl_o && !sda_o; endproperty
  a_scl: assert property (p_scl) else $error("scl or sda driven");
  property p_en; !en_i [*5] |-> !sda_oe_o; endproperty
  a_en: assert property (p_en) else $error("sda driven while disabled");
  property p_uvlo; uvlo_i [*5] |-> !sda_oe_o; endproperty
  a_uvlo: assert property (p_uvlo) else $error("sda driven in lockout");
  property p_hold; $changed(sda_oe_o) && en_i && !uvlo_i |-> !scl_i; endproperty
  a_hold: assert property (p_hold) else $error("sda moved with scl high");
  property p_ack; $rose(sda_oe_o) |-> sda_oe_o [*8]; endproperty
  a_ack: assert property (p_ack) else $error("pulldown too short");
  property p_start; $fell(sda_i) && scl_i && en_i && !uvlo_i |-> ##[1:16] busy_o; endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop; $rose(sda_i) && scl_i |-> ##[1:16] !busy_o; endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_commit; wr_stb_o |-> !busy_o; endproperty
  a_commit: assert property (p_commit) else $error("commit inside frame");
  property p_idle; !busy_o |-> !sda_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("sda driven on idle bus");
endmodule
bind lrs_port lrs_monitor MON (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .en_i(en_i),
  .uvlo_i(uvlo_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .wr_stb_o(wr_stb_o), .busy_o(busy_o));
`default_nettype wire

// File: testbench/lrs_master.sv
// Purpose: behavioural i2c bus master for the port bench
// Assumes: open-drain lines resolved with pull-ups by the bench
// Notes: scl near 390 kHz; a 160 ns scl would starve the 4-sample filter
`default_nettype none
module lrs_master
(
  input  wire logic sda_i,
  output logic      scl_lo_o,
  output logic      sda_lo_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam time Q = 640ns;
  // ====================
  // conditions and bytes
  initial scl_lo_o = 1'b0;
  initial sda_lo_o = 1'b0;
  task automatic start();
    sda_lo_o = 1'b0;
    #Q scl_lo_o = 1'b0;
    #(2*Q) sda_lo_o = 1'b1;
    #(2*Q) scl_lo_o = 1'b1;
    #Q;
  endtask
  task automatic stop();
    sda_lo_o = 1'b1;
    #Q scl_lo_o = 1'b0;
    #(2*Q) sda_lo_o = 1'b0;
    #(2*Q);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    logic [8:0] s;
    logic [8:0] w;
    w = {d, a};
    for (int i = 8; i >= 0; i--)
    begin
      sda_lo_o = !w[i];
      #Q scl_lo_o = 1'b0;
      #Q s[i] = sda_i;
      #Q scl_lo_o = 1'b1;
      #Q;
    end
    q = s[8:1];
    r = s[0];
  endtask
endmodule
`default_nettype wire

// File: testbench/test_i2c_register_slave_port.sv
// Purpose: self-checking bench for the i2c register port
// Assumes: variant 0 (address 28h), ce_i held high
// Notes: register file is a random array; commits captured from strobes
`default_nettype none
module test_i2c_register_slave_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic            ref_clk_i = 1'b0;
  logic            rstn_i    = 1'b0;
  logic            en_i      = 1'b1;
  logic            uvlo_i    = 1'b0;
  logic [7:0]      regs [256];
  logic [7:0]      dq [4];
  logic [15:0]     cq [$];
  int              failures  = 0;
  int              checked   = 0;
  wire logic       scl_lo, sda_lo, sda_oe, scl_oe, stb;
  wire logic [7:0] ptr, wa, wd;
  wire logic       scl = !(scl_lo | scl_oe);
  wire logic       sda = !(sda_lo | sda_oe);
  // ====================
  // harness
  always #10 ref_clk_i = !ref_clk_i;
  always @(posedge ref_clk_i) if (stb === 1'b1) cq.push_back({wa, wd});
  lrs_master M (.sda_i(sda), .scl_lo_o(scl_lo), .sda_lo_o(sda_lo));
  lrs_port DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .en_i(en_i),
    .uvlo_i(uvlo_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .scl_o(),
    .scl_oe_o(scl_oe), .reg_ptr_o(ptr), .rd_data_i(regs[ptr]), .wr_stb_o(stb),
    .wr_addr_o(wa), .wr_data_o(wd), .busy_o());
  task automatic tally_and_finish();
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string s, input logic [15:0] v, input logic [15:0] x);
    checked++;
    if (v !== x)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, x, v);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    logic [7:0] q;
    logic       r;
    M.xfer(b, 1'b1, q, r);
    check("ack", 16'(r), 16'(e));
  endtask
  initial
  begin
    #2ms;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    int         p;
    int         n;
    logic [7:0] got;
    logic       ack;
    void'($urandom(32'h8989be1d));
    foreach (regs[i]) regs[i] = $urandom;
    repeat (10) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    #1;
    for (int t = 0; t < 4; t++)
    begin
      p = (t == 0) ? 251 : $urandom_range(0, 251);
      n = (t < 2) ? 1 + 3 * t : $urandom_range(1, 4);
      cq.delete();
      M.start();
      send(8'h50, 1'b0);
      send(p[7:0], 1'b0);
      for (int k = 0; k < n; k++)
      begin
        dq[k] = $urandom;
        send(dq[k], 1'b0);
      end
      check("early commit", 16'(cq.size()), 16'h0000);
      M.stop();
      repeat (60) @(posedge ref_clk_i);
      check("commit count", 16'(cq.size()), 16'(n));
      for (int k = 0; k < n; k++)
        check("commit", cq[k], {p[7:0] + 8'(k), dq[k]});
      cq.delete();
      M.start();
      send(8'h50, 1'b0);
      send(p[7:0], 1'b0);
      M.start();
      send(8'h51, 1'b0);
      for (int k = 0; k < n; k++)
      begin
        M.xfer(8'hff, k == n - 1, got, ack);
        check("read", 16'(got), 16'(regs[p + k]));
      end
      M.stop();
      repeat (60) @(posedge ref_clk_i);
      check("read commits", 16'(cq.size()), 16'h0000);
    end
    for (int c = 0; c < 3; c++)
    begin
      en_i = (c != 1);
      uvlo_i = (c == 2);
      repeat (10) @(posedge ref_clk_i);
      #1;
      M.start();
      send((c == 0) ? 8'h52 : 8'h50, 1'b1);
      send(8'h00, 1'b1);
      M.stop();
      en_i = 1'b1;
      uvlo_i = 1'b0;
    end
    repeat (60) @(posedge ref_clk_i);
    check("refused commits", 16'(cq.size()), 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
